// >>> hw/icfg_top.v
// Input capture channel: edge filter, glitch event, counter and registers
// Operation
// - Unexpected input change before filter threshold gives one-cycle glitch if the filter counter is nonzero.
// - Glitch coinciding with threshold reach still produces the event.
// - Glitch event stays one cycle even when the change persists.
// - Every glitch event sets glitch notify flag, raising interrupt when irq_en_r bit 1 is set.
// - External capture selected to glitch fires on every glitch event.
// - Clearing notify flag never retriggers interrupt without new glitch.
// - Per-edge mode bit 0 selects immediate propagation; filter_enable gates.
// - Immediate mode with threshold 0: counter neither increments nor grows.
// - Filter counter advances once per selected sample clock tick.
// - Writing 1 to channel reset bit returns channel to reset values.
// - Enabling channel starts counter from reset value.
// - Sampling mode 101 one-shot: each tick loads counter, sets new value.
`default_nettype none
`include "icfg_consts.vh"

module icfg_top #(
  parameter integer FCW = 16,
  parameter integer CW = 24
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire chan_in,
  output reg filtered_out_r,
  output reg glitch_event_r,
  output reg external_capture_signal_r,
  output reg irq_r
);
  // ********************************************************
  // Registers and state
  // ********************************************************
  reg [12:0] ctrl_r;
  reg [FCW-1:0] rise_filter_threshold_r;
  reg [FCW-1:0] fall_filter_threshold_r;
  reg [CW-1:0] counter_start_value_r;
  reg [CW-1:0] channel_counter_r;
  reg [CW-1:0] capture_reg_zero_r;
  reg [CW-1:0] capture_reg_one_r;
  reg [1:0] status_r;
  reg [1:0] irq_en_r;
  reg [FCW-1:0] filt_cnt_r;
  reg [2:0] sync_r;
  reg sync_lvl_r;
  reg en_d_r;
  reg aw_hold_r;
  reg w_hold_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  wire channel_enable = ctrl_r[`ICFG_CTRL_EN];
  wire [2:0] channel_mode_select =
    ctrl_r[`ICFG_CTRL_MODE_HI:`ICFG_CTRL_MODE_LO];
  wire one_shot_select = ctrl_r[`ICFG_CTRL_OSM];
  wire input_select_level = ctrl_r[`ICFG_CTRL_ISL];
  wire filter_enable = ctrl_r[`ICFG_CTRL_FILTER_ENABLE];
  wire rise_filter_mode = ctrl_r[`ICFG_CTRL_FMODE_RISE];
  wire fall_filter_mode = ctrl_r[`ICFG_CTRL_FMODE_FALL];
  wire ext_sel_glitch = ctrl_r[`ICFG_CTRL_EXT_SEL];
  wire [2:0] clk_sel = ctrl_r[`ICFG_CTRL_CLK_HI:`ICFG_CTRL_CLK_LO];

  // ********************************************************
  // Sample clock enable
  // ********************************************************
  wire sample_tick;
  icfg_clk_sel u_clk_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(clk_sel),
    .tick_r(sample_tick)
  );

  // ********************************************************
  // Bus write decode
  // ********************************************************
  wire wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire wr_clear = wr_fire && aw_addr_r == `ICFG_OFF_CLEAR;
  wire wr_reset = wr_fire && aw_addr_r == `ICFG_OFF_RESET;
  // Channel reset request, one cycle
  wire chan_rst = wr_reset && w_data_r[`ICFG_CHANNEL_RESET_BIT];
  wire [1:0] clr_bits = wr_clear ? w_data_r[1:0] : 2'h0;

  // ********************************************************
  // Input synchroniser: change counts when stages two and three agree
  // ********************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_r <= 3'h0;
      sync_lvl_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], chan_in};
      if (sync_r[1] == sync_r[2]) begin
        sync_lvl_r <= sync_r[2];
      end
    end
  end

  // ********************************************************
  // Edge filter
  // ********************************************************
  // Pending edge direction is set by the filtered level: a rise when low
  wire rising_dir = !filtered_out_r;
  wire imm_mode = rising_dir ? !rise_filter_mode : !fall_filter_mode;
  wire [FCW-1:0] thr = rising_dir ? rise_filter_threshold_r
                                  : fall_filter_threshold_r;
  wire in_diff = sync_lvl_r != filtered_out_r;
  reg [FCW-1:0] filt_cnt_nxt;
  reg filtered_nxt;
  reg glitch_nxt;
  reg in_prev_r;

  // In immediate mode the output follows at once and the counter times an
  // acceptance window in which further changes are glitches. In delay mode
  // the counter must reach the threshold before the output follows.
  always @* begin
    filt_cnt_nxt = filt_cnt_r;
    filtered_nxt = filtered_out_r;
    glitch_nxt = 1'b0;
    if (!filter_enable) begin
      filtered_nxt = sync_lvl_r;
      filt_cnt_nxt = {FCW{1'b0}};
    end else if (imm_mode) begin
      if (filt_cnt_r != {FCW{1'b0}}) begin
        // Acceptance window still open
        if (sync_lvl_r != in_prev_r) begin
          glitch_nxt = 1'b1;
        end
        if (sample_tick) begin
          filt_cnt_nxt = filt_cnt_r - {{(FCW-1){1'b0}}, 1'b1};
        end
      end else if (in_diff) begin
        filtered_nxt = sync_lvl_r;
        // Zero threshold: no window, no count kept across edges
        filt_cnt_nxt = thr;
      end
    end else begin
      if (in_diff) begin
        if (sample_tick) begin
          filt_cnt_nxt = filt_cnt_r + {{(FCW-1){1'b0}}, 1'b1};
        end
        if (filt_cnt_nxt >= thr) begin
          filtered_nxt = sync_lvl_r;
          filt_cnt_nxt = {FCW{1'b0}};
        end
      end else if (filt_cnt_r != {FCW{1'b0}}) begin
        // Input fell back before threshold, even in the reaching cycle
        glitch_nxt = (sync_lvl_r != in_prev_r);
        filt_cnt_nxt = {FCW{1'b0}};
      end
    end
  end

  // Glitch is derived from an input edge only, so it never stretches
  always @(posedge aclk) begin
    if (!aresetn || chan_rst) begin
      filt_cnt_r <= {FCW{1'b0}};
      filtered_out_r <= 1'b0;
      glitch_event_r <= 1'b0;
      in_prev_r <= 1'b0;
      external_capture_signal_r <= 1'b0;
    end else begin
      filt_cnt_r <= filt_cnt_nxt;
      filtered_out_r <= filtered_nxt;
      in_prev_r <= sync_lvl_r;
      glitch_event_r <= glitch_nxt;
      external_capture_signal_r <= glitch_nxt && ext_sel_glitch;
    end
  end

  // ********************************************************
  // Channel counter and capture
  // ********************************************************
  reg filt_prev_r;
  wire edge_ev = (filtered_out_r != filt_prev_r) &&
                 (filtered_out_r == input_select_level);
  wire en_rise = channel_enable && !en_d_r;
  wire gps_mode = channel_mode_select == `ICFG_MODE_GPS;
  wire gps_ev = channel_enable && gps_mode && sample_tick;
  reg new_value_flag_ev;
  reg [CW-1:0] cnt_base;

  always @* begin
    // A freshly enabled channel counts from the reset value
    cnt_base = en_rise ? {CW{1'b0}} : channel_counter_r;
    new_value_flag_ev = 1'b0;
    if (gps_ev) begin
      new_value_flag_ev = 1'b1;
    end else if (channel_enable && !gps_mode && edge_ev) begin
      new_value_flag_ev = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn || chan_rst) begin
      channel_counter_r <= {CW{1'b0}};
      capture_reg_zero_r <= {CW{1'b0}};
      capture_reg_one_r <= {CW{1'b0}};
      filt_prev_r <= 1'b0;
      en_d_r <= 1'b0;
    end else begin
      filt_prev_r <= filtered_out_r;
      en_d_r <= channel_enable;
      if (en_rise) begin
        capture_reg_zero_r <= {CW{1'b0}};
        capture_reg_one_r <= {CW{1'b0}};
      end
      if (gps_ev) begin
        // Capture then reload; one-shot reloads the reset value
        capture_reg_zero_r <= cnt_base;
        capture_reg_one_r <= capture_reg_zero_r;
        channel_counter_r <= one_shot_select ? {CW{1'b0}}
                                             : counter_start_value_r;
      end else if (channel_enable && new_value_flag_ev) begin
        capture_reg_zero_r <= cnt_base;
        capture_reg_one_r <= capture_reg_zero_r;
        channel_counter_r <= {CW{1'b0}};
      end else if (channel_enable && sample_tick) begin
        channel_counter_r <= cnt_base + {{(CW-1){1'b0}}, 1'b1};
      end else if (en_rise) begin
        channel_counter_r <= {CW{1'b0}};
      end
    end
  end

  // ********************************************************
  // Notify flags and interrupt
  // ********************************************************
  wire [1:0] ev_bits = {glitch_event_r, new_value_flag_ev};
  always @(posedge aclk) begin
    if (!aresetn || chan_rst) begin
      status_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      status_r <= (status_r & ~clr_bits) | ev_bits;
      // Level from sticky flags only, so a clear cannot retrigger
      irq_r <= |(((status_r & ~clr_bits) | ev_bits) & irq_en_r);
    end
  end

  // ********************************************************
  // AXI4-Lite write channel
  // ********************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ICFG_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r > `ICFG_OFF_FILT_CNT) ? `ICFG_RESP_SLVERR
                                                        : `ICFG_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; whole words only, byte strobes are ignored
  always @(posedge aclk) begin
    if (!aresetn || chan_rst) begin
      ctrl_r <= 13'h0000;
      rise_filter_threshold_r <= {FCW{1'b0}};
      fall_filter_threshold_r <= {FCW{1'b0}};
      counter_start_value_r <= {CW{1'b0}};
      irq_en_r <= 2'h0;
    end else if (wr_fire) begin
      case (aw_addr_r)
        `ICFG_OFF_CTRL: begin
          ctrl_r <= w_data_r[12:0];
        end
        `ICFG_OFF_FLT_RISE: begin
          rise_filter_threshold_r <= w_data_r[FCW-1:0];
        end
        `ICFG_OFF_FLT_FALL: begin
          fall_filter_threshold_r <= w_data_r[FCW-1:0];
        end
        `ICFG_OFF_CNT_START: begin
          counter_start_value_r <= w_data_r[CW-1:0];
        end
        `ICFG_OFF_IRQ_EN: begin
          irq_en_r <= w_data_r[1:0];
        end
        default: begin
          irq_en_r <= irq_en_r;
        end
      endcase
    end
  end

  // ********************************************************
  // AXI4-Lite read channel
  // ********************************************************
  reg [31:0] rd_val;
  reg rd_err;
  always @* begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    case ({s_axi_araddr[7:2], 2'b00})
      `ICFG_OFF_CTRL: rd_val = {19'h00000, ctrl_r};
      `ICFG_OFF_FLT_RISE: rd_val[FCW-1:0] = rise_filter_threshold_r;
      `ICFG_OFF_FLT_FALL: rd_val[FCW-1:0] = fall_filter_threshold_r;
      `ICFG_OFF_CNT_START: rd_val[CW-1:0] = counter_start_value_r;
      `ICFG_OFF_CNT: rd_val[CW-1:0] = channel_counter_r;
      `ICFG_OFF_CAP0: rd_val[CW-1:0] = capture_reg_zero_r;
      `ICFG_OFF_CAP1: rd_val[CW-1:0] = capture_reg_one_r;
      `ICFG_OFF_STATUS: rd_val[1:0] = status_r;
      `ICFG_OFF_CLEAR: rd_val = 32'h00000000;
      `ICFG_OFF_IRQ_EN: rd_val[1:0] = irq_en_r;
      `ICFG_OFF_RESET: rd_val = 32'h00000000;
      `ICFG_OFF_FILT_CNT: rd_val[FCW-1:0] = filt_cnt_r;
      default: rd_err = 1'b1;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ICFG_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_err ? `ICFG_RESP_SLVERR : `ICFG_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hw/icfg_consts.vh
// Constants for the input capture channel with edge filter and glitch event
`ifndef ICFG_CONSTS_VH
`define ICFG_CONSTS_VH

// Register byte offsets
`define ICFG_OFF_CTRL 8'h00
`define ICFG_OFF_FLT_RISE 8'h04
`define ICFG_OFF_FLT_FALL 8'h08
`define ICFG_OFF_CNT_START 8'h0c
`define ICFG_OFF_CNT 8'h10
`define ICFG_OFF_CAP0 8'h14
`define ICFG_OFF_CAP1 8'h18
`define ICFG_OFF_STATUS 8'h1c
`define ICFG_OFF_CLEAR 8'h20
`define ICFG_OFF_IRQ_EN 8'h24
`define ICFG_OFF_RESET 8'h28
`define ICFG_OFF_FILT_CNT 8'h2c

// Control register fields
`define ICFG_CTRL_EN 0
`define ICFG_CTRL_MODE_LO 1
`define ICFG_CTRL_MODE_HI 3
`define ICFG_CTRL_OSM 4
`define ICFG_CTRL_ISL 5
`define ICFG_CTRL_FILTER_ENABLE 6
`define ICFG_CTRL_FMODE_RISE 7
`define ICFG_CTRL_FMODE_FALL 8
`define ICFG_CTRL_EXT_SEL 9
`define ICFG_CTRL_CLK_LO 10
`define ICFG_CTRL_CLK_HI 12
`define ICFG_CTRL_MASK 32'h00001fff

// Status bits
`define ICFG_ST_NEW_VALUE_FLAG 0
`define ICFG_ST_GLITCH 1
`define ICFG_ST_MASK 2'h3

// Mode codes
`define ICFG_MODE_EDGE 3'h0
`define ICFG_MODE_GPS 3'h5

// Channel reset bit position
`define ICFG_CHANNEL_RESET_BIT 0

// Divider ratio of the fastest sample clock and the step added per select code
`define ICFG_DIV0 16'h0001
`define ICFG_DIV_STEP 16'h0004

// AXI responses
`define ICFG_RESP_OKAY 2'h0
`define ICFG_RESP_SLVERR 2'h2

`endif

// >>> hw/icfg_clk_sel.v
// Sample clock enable generator with eight selectable rates
`default_nettype none
`include "icfg_consts.vh"

module icfg_clk_sel #(
  parameter integer NUM_CLK = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [2:0] sel,
  output reg tick_r
);
  // ********************************************************
  // Free running dividers, one per rate
  // ********************************************************
  wire [NUM_CLK-1:0] tick_all;
  genvar g;
  generate
    for (g = 0; g < NUM_CLK; g = g + 1) begin : gen_div
      localparam integer RATIO_I = `ICFG_DIV0 + g * `ICFG_DIV_STEP;
      localparam [15:0] RATIO = RATIO_I[15:0];
      reg [15:0] cnt_r;
      // Ratio 1 gives a tick every cycle, the fastest rate
      always @(posedge aclk) begin
        if (!aresetn || cnt_r >= RATIO - 16'h0001) begin
          cnt_r <= 16'h0000;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
      assign tick_all[g] = (cnt_r >= RATIO - 16'h0001);
    end
  endgenerate

  // Registered tick of the chosen rate; one-cycle pulse except at ratio 1
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_all[sel];
    end
  end
endmodule
`default_nettype wire

// >>> bench/icfg_top_sva.sv
// Checker of bus handshakes, event pulses and interrupt level at the ports
`default_nettype none
module icfg_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic glitch_event_r,
  input wire logic external_capture_signal_r,
  input wire logic irq_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ********
  // Assertions
  // ********
  a_glitch_single: assert property (glitch_event_r |=> !glitch_event_r)
    else $error("glitch event wider than one cycle");
  a_ext_glitch: assert property (
    external_capture_signal_r |-> glitch_event_r)
    else $error("capture pulse without glitch event");
  a_reset_quiet: assert property ($rose(aresetn) |-> !irq_r && !glitch_event_r
    && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read data late");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready wider than one cycle");
  // Only a register write may lower the interrupt; a clear or reset drops it as bvalid rises, an enable write a cycle later
  a_irq_sticky: assert property ($fell(irq_r) |-> s_axi_bvalid)
    else $error("interrupt dropped without a write");
  // ********
  // Covers
  // ********
  c_glitch: cover property (glitch_event_r);
  c_ext: cover property (external_capture_signal_r);
  c_irq: cover property ($rose(irq_r));
endmodule
bind icfg_top icfg_top_sva u_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .glitch_event_r(glitch_event_r), .irq_r(irq_r),
  .external_capture_signal_r(external_capture_signal_r));
`default_nettype wire

// >>> bench/icfg_pin_model.sv
// Model of the external pin that feeds the capture channel
`default_nettype none
module icfg_pin_model (
  input wire logic aclk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'h0;
  // Changes land just after an edge, as from an unrelated outside source
  task automatic drive(input logic lvl);
    @(posedge aclk);
    pin <= lvl;
  endtask
  // A short excursion that the filter may treat as a glitch
  task automatic pulse(input int w);
    drive(1'h1);
    repeat (w) @(posedge aclk);
    pin <= 1'h0;
  endtask
endmodule
`default_nettype wire

// >>> bench/input_channel_filter_glitch_test.sv
// Self-checking bench for the filtered input capture channel
`default_nettype none
`include "icfg_consts.vh"
module input_channel_filter_glitch_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] DLY = 32'h000003c1; // Both edges delayed, ext on
  localparam logic [31:0] IMM = 32'h00000041; // Both edges immediate
  localparam logic [31:0] GPS = 32'h0000003b; // Mode 101, one-shot, level
  localparam logic [31:0] SLOW = 32'h00001c01; // Plain count, slowest tick
  localparam logic [7:0] ROFF [5] = '{`ICFG_OFF_CTRL, `ICFG_OFF_FLT_RISE,
    `ICFG_OFF_IRQ_EN, `ICFG_OFF_STATUS, `ICFG_OFF_CNT};
  logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, arv = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, v;
  logic [1:0] br, rr, rsp;
  logic awrdy, wrdy, bv, arrdy, rv, pin, filt, gl, ext, irq, fprev;
  int error_cnt, checks, gn, en, fn, g0, e0, f0, n, d1;

  icfg_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'h1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(1'h1), .chan_in(pin), .filtered_out_r(filt),
    .glitch_event_r(gl), .external_capture_signal_r(ext), .irq_r(irq));
  icfg_pin_model u_pin (.aclk(aclk), .pin(pin));

  always #25 aclk = ~aclk;
  // Count event pulses and filtered rises, seen before the edge updates
  always @(posedge aclk) begin
    if (gl === 1'h1) gn++;
    if (ext === 1'h1) en++;
    if (filt === 1'h1 && fprev !== 1'h1) fn++;
    fprev = filt;
  end
  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Ready is sampled before the edge's own updates, so release is in step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    while (k < 50) begin
      @(posedge aclk);
      k++;
      if (awrdy === 1'h1) awv <= 1'h0;
      if (wrdy === 1'h1) wv <= 1'h0;
      if (bv === 1'h1) break;
    end
    rsp = br;
    chk("write_answer", 1, k < 50);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    k = 0;
    ara <= a;
    arv <= 1'h1;
    while (k < 50) begin
      @(posedge aclk);
      k++;
      if (arrdy === 1'h1) arv <= 1'h0;
      if (rv === 1'h1) break;
    end
    d = rdat;
    rsp = rr;
    chk("read_answer", 1, k < 50);
  endtask
  // Drive the pin and count cycles until the filtered level follows
  task automatic settle(input logic lvl, output int c);
    u_pin.drive(lvl);
    c = 0;
    while (filt !== lvl && c < 100) begin
      @(posedge aclk);
      c++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`ICFG_OFF_STATUS, v);
    chk("status_rst", 0, v);
    rd(8'h30, v);
    chk("rd_unmapped", `ICFG_RESP_SLVERR, rsp);
    wr(8'h30, 32'h1);
    chk("wr_unmapped", `ICFG_RESP_SLVERR, rsp);
    wr(`ICFG_OFF_CTRL, 32'hffffffff);
    rd(`ICFG_OFF_CTRL, v);
    chk("ctrl_mask", `ICFG_CTRL_MASK, v);
    $display("test regs done");
    // Masked glitch sets the sticky flag but keeps the line low
    wr(`ICFG_OFF_CTRL, DLY);
    wr(`ICFG_OFF_FLT_RISE, 32'h8);
    wr(`ICFG_OFF_FLT_FALL, 32'h8);
    wr(`ICFG_OFF_IRQ_EN, 32'h0);
    g0 = gn;
    e0 = en;
    u_pin.pulse(3);
    repeat (12) @(posedge aclk);
    chk("glitch_once", g0 + 1, gn);
    chk("ext_once", e0 + 1, en);
    chk("filt_held", 0, filt);
    rd(`ICFG_OFF_STATUS, v);
    chk("glitch_flag", 2, v);
    chk("irq_masked", 0, irq);
    wr(`ICFG_OFF_IRQ_EN, 32'h2);
    repeat (12) @(posedge aclk);
    chk("irq_raised", 1, irq);
    wr(`ICFG_OFF_CLEAR, 32'h2);
    repeat (12) @(posedge aclk);
    rd(`ICFG_OFF_STATUS, v);
    chk("flag_clear", 0, v);
    chk("irq_quiet", 0, irq);
    $display("test glitch done");
    // One more threshold step must cost exactly one sample tick
    settle(1'h1, d1);
    settle(1'h0, n);
    wr(`ICFG_OFF_FLT_RISE, 32'h9);
    settle(1'h1, n);
    chk("delay_step", d1 + 1, n);
    settle(1'h0, n);
    // Every width is a glitch or a pass, never lost at threshold; a pin
    // pulse of one cycle never gets past the synchroniser, so start at two
    for (int w = 2; w < 13; w++) begin
      g0 = gn;
      f0 = fn;
      u_pin.pulse(w);
      repeat (30) @(posedge aclk);
      chk("glitch_or_pass", 1, gn - g0 + fn - f0);
    end
    $display("test threshold done");
    wr(`ICFG_OFF_CTRL, IMM);
    wr(`ICFG_OFF_FLT_RISE, 32'h0);
    wr(`ICFG_OFF_FLT_FALL, 32'h0);
    g0 = gn;
    for (int i = 0; i < 4; i++) begin
      settle(i % 2 == 0, n);
      chk("imm_follow", i % 2 == 0, filt);
      rd(`ICFG_OFF_FILT_CNT, v);
      chk("filt_cnt_zero", 0, v);
    end
    chk("no_window", g0, gn);
    $display("test immediate done");
    // A re-enabled channel must not resume from its stale count
    repeat (20) @(posedge aclk);
    wr(`ICFG_OFF_CTRL, 32'h0);
    rd(`ICFG_OFF_CNT, v);
    chk("cnt_stale", 1, v > 32'h2);
    wr(`ICFG_OFF_CTRL, SLOW);
    rd(`ICFG_OFF_CNT, v);
    chk("cnt_enable", 1, v < 32'h2);
    // Counter cleared through gated sampling before the channel is used;
    // old flags are cleared first so that only the sampling sets new value
    wr(`ICFG_OFF_CTRL, 32'h0);
    wr(`ICFG_OFF_CLEAR, 32'h3);
    wr(`ICFG_OFF_CNT_START, 32'h0);
    wr(`ICFG_OFF_CTRL, GPS);
    n = 0;
    do begin
      rd(`ICFG_OFF_STATUS, v);
      n++;
    end while (v[0] !== 1'h1 && n < 20);
    chk("new_value_flag", 1, v[0]);
    rd(`ICFG_OFF_CNT, v);
    chk("cnt_loaded", 0, v);
    wr(`ICFG_OFF_CTRL, 32'h0);
    wr(`ICFG_OFF_CTRL, SLOW);
    rd(`ICFG_OFF_CNT, v);
    chk("cnt_restart", 1, v < 32'h2);
    wr(`ICFG_OFF_CTRL, DLY);
    wr(`ICFG_OFF_FLT_RISE, 32'h5);
    wr(`ICFG_OFF_IRQ_EN, 32'h3);
    wr(`ICFG_OFF_RESET, 32'h1);
    for (int i = 0; i < 5; i++) begin
      rd(ROFF[i], v);
      chk("chan_reset", 0, v);
    end
    $display("test channel reset done");
    print_verdict;
  end
  // Cut a hang short well beyond the expected run length
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
